// >>> src/dsam_top.sv
// dual alarm monitor: registers, source select, status flags and indicator lines
`timescale 1ns/10ps
module dsam_top #(
    parameter int DATA_W = dsam_pkg::DATA_W,
    parameter int NUM_SRC = dsam_pkg::NUM_SRC,
    parameter int HIST_DEPTH = dsam_pkg::HIST_DEPTH
) (
    input wire logic REF_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic CLK_EN_IN,
    input wire logic SAMPLE_STROBE_IN,
    input wire logic [NUM_SRC*DATA_W-1:0] RAW_DATA_IN,
    input wire logic [NUM_SRC*DATA_W-1:0] FILT_DATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [6:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    output logic [15:0] REG_RDATA_OUT,
    output logic REG_RVALID_OUT,
    input wire logic DRDY_ON_LINE_ONE_IN,
    input wire logic DRDY_ON_LINE_TWO_IN,
    output logic GP_LINE_ONE_OUT,
    output logic GP_LINE_ONE_OE_OUT,
    output logic GP_LINE_TWO_OUT,
    output logic GP_LINE_TWO_OE_OUT,
    output logic [1:0] ALARM_FLAG_OUT
);
    // word decode: byte address bit 0 selects the upper byte
    function automatic logic hit(input logic [6:0] addr, input logic [6:0] base);
        return addr[6:1] == base[6:1];
    endfunction

    // pick one source word; code 0 or above 7 yields zero
    function automatic logic [DATA_W-1:0] pick(input logic [3:0] code,
                                               input logic [NUM_SRC*DATA_W-1:0] bus);
        logic [DATA_W-1:0] val;
        val = '0;
        for (int k = 0; k < NUM_SRC; k++) begin
            if (code == 4'(k + 1)) begin
                val = bus[k*DATA_W +: DATA_W];
            end
        end
        return val;
    endfunction

    logic [15:0] threshold [2];
    logic [15:0] count [2];
    logic [15:0] config_reg;
    logic [1:0] flag;
    logic sample_seen;
    wire logic [1:0] cond;

    // ---- register writes, one byte per access
    wire logic upper = REG_ADDR_IN[0];
    wire logic [15:0] byte_mask = upper ? 16'hff00 : 16'h00ff;
    wire logic [15:0] wide_data = {REG_WDATA_IN, REG_WDATA_IN};
    wire logic wr_cfg = REG_WR_IN && hit(REG_ADDR_IN, dsam_pkg::ADDR_CONFIG);
    wire logic [1:0] wr_thr;
    wire logic [1:0] wr_cnt;
    assign wr_thr[0] = REG_WR_IN && hit(REG_ADDR_IN, dsam_pkg::ADDR_THRESH1);
    assign wr_thr[1] = REG_WR_IN && hit(REG_ADDR_IN, dsam_pkg::ADDR_THRESH2);
    assign wr_cnt[0] = REG_WR_IN && hit(REG_ADDR_IN, dsam_pkg::ADDR_COUNT1);
    assign wr_cnt[1] = REG_WR_IN && hit(REG_ADDR_IN, dsam_pkg::ADDR_COUNT2);

    wire logic [15:0] next_cfg =
        ((config_reg & ~byte_mask) | (wide_data & byte_mask)) & dsam_pkg::MASK_CONFIG;

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            config_reg <= dsam_pkg::RST_CONFIG;
        end else if (CLK_EN_IN && wr_cfg) begin
            config_reg <= next_cfg;
        end
    end

    // ---- per-channel registers and compare engines
    wire logic filt = config_reg[dsam_pkg::CFG_FILT_BIT];
    wire logic [NUM_SRC*DATA_W-1:0] src_bus = filt ? FILT_DATA_IN : RAW_DATA_IN;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_alarm
            localparam int SRC_LSB = (i == 0) ? dsam_pkg::CFG_SRC1_LSB : dsam_pkg::CFG_SRC2_LSB;
            wire logic [3:0] code = config_reg[SRC_LSB +: 4];
            wire logic enable = (code != dsam_pkg::SRC_DISABLE) && (code <= dsam_pkg::SRC_LAST);
            wire logic dynamic = config_reg[dsam_pkg::CFG_DYN1_BIT + i];
            wire logic [15:0] next_thr =
                ((threshold[i] & ~byte_mask) | (wide_data & byte_mask)) & dsam_pkg::MASK_THRESH;
            wire logic [15:0] next_cnt =
                ((count[i] & ~byte_mask) | (wide_data & byte_mask)) & dsam_pkg::MASK_COUNT;

            always_ff @(posedge REF_CLK_IN) begin
                if (SYS_RST_IN) begin
                    threshold[i] <= dsam_pkg::RST_THRESH;
                    count[i] <= dsam_pkg::RST_COUNT;
                end else if (CLK_EN_IN) begin
                    if (wr_thr[i]) begin
                        threshold[i] <= next_thr;
                    end
                    if (wr_cnt[i]) begin
                        count[i] <= next_cnt;
                    end
                end
            end

            // each alarm keeps its own settings and history
            dsam_channel #(
                .DATA_W(DATA_W),
                .DEPTH(HIST_DEPTH)
            ) u_channel (
                .clk_in(REF_CLK_IN),
                .rst_in(SYS_RST_IN),
                .ce_in(CLK_EN_IN),
                .sample_in(SAMPLE_STROBE_IN),
                .enable_in(enable),
                .dynamic_in(dynamic),
                .threshold_in(threshold[i]),
                .count_in(count[i][dsam_pkg::CNT_MSB:0]),
                .src_in(pick(code, src_bus)),
                .cond_out(cond[i])
            );
        end
    endgenerate

    // ---- diagnostic flags: cleared by a status read, a fresh sample wins
    wire logic diag_rd = REG_RD_IN && hit(REG_ADDR_IN, dsam_pkg::ADDR_DIAG);
    wire logic [1:0] set_flag = {2{sample_seen}} & cond;
    wire logic [1:0] next_flag = (flag & {2{~diag_rd}}) | set_flag;

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            sample_seen <= 1'b0;
            flag <= 2'b00;
        end else if (CLK_EN_IN) begin
            sample_seen <= SAMPLE_STROBE_IN;
            flag <= next_flag;
        end
    end

    assign ALARM_FLAG_OUT = flag;

    // ---- register reads, answered one cycle later
    wire logic [15:0] diag_word = 16'({flag, 8'h00});
    wire logic [15:0] rd_word =
        hit(REG_ADDR_IN, dsam_pkg::ADDR_THRESH1) ? threshold[0] :
        hit(REG_ADDR_IN, dsam_pkg::ADDR_THRESH2) ? threshold[1] :
        hit(REG_ADDR_IN, dsam_pkg::ADDR_COUNT1) ? count[0] :
        hit(REG_ADDR_IN, dsam_pkg::ADDR_COUNT2) ? count[1] :
        hit(REG_ADDR_IN, dsam_pkg::ADDR_CONFIG) ? config_reg :
        diag_rd ? diag_word : 16'h0000;

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            REG_RDATA_OUT <= 16'h0000;
            REG_RVALID_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            REG_RVALID_OUT <= REG_RD_IN;
            if (REG_RD_IN) begin
                REG_RDATA_OUT <= rd_word;
            end
        end
    end

    // ---- indicator line ownership and level
    wire logic any_alarm = |cond;
    wire logic ind_en = config_reg[dsam_pkg::CFG_IND_EN_BIT];
    wire logic ind_high = config_reg[dsam_pkg::CFG_IND_POL_BIT];
    wire logic ind_two = config_reg[dsam_pkg::CFG_IND_LINE_BIT];
    wire logic ind_level = ind_high ? any_alarm : ~any_alarm;
    // data-ready claims a line first, then the enabled indicator on its selected line; otherwise it stays free for general use
    wire logic own_one = ind_en && !ind_two && !DRDY_ON_LINE_ONE_IN;
    wire logic own_two = ind_en && ind_two && !DRDY_ON_LINE_TWO_IN;

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            GP_LINE_ONE_OE_OUT <= 1'b0;
            GP_LINE_TWO_OE_OUT <= 1'b0;
            GP_LINE_ONE_OUT <= 1'b0;
            GP_LINE_TWO_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            GP_LINE_ONE_OE_OUT <= own_one;
            GP_LINE_TWO_OE_OUT <= own_two;
            GP_LINE_ONE_OUT <= own_one & ind_level;
            GP_LINE_TWO_OUT <= own_two & ind_level;
        end
    end

    // ---- checks
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    AST_RD_CLEAR: assert property ((CLK_EN_IN && diag_rd && !sample_seen) |=> flag == 2'b00)
        else $error("status read did not clear the alarm flags");
    AST_SET_WINS: assert property ((CLK_EN_IN && sample_seen && cond[0]) |=> ALARM_FLAG_OUT[0])
        else $error("alarm 1 flag not set after a tripped sample");
    AST_IND_OFF: assert property ((CLK_EN_IN && !ind_en)
        |=> !GP_LINE_ONE_OE_OUT && !GP_LINE_TWO_OE_OUT)
        else $error("indicator drives a line while disabled");
    AST_IND_LEVEL: assert property ((CLK_EN_IN && own_one)
        |=> GP_LINE_ONE_OUT == ($past(ind_high) ? $past(any_alarm) : !$past(any_alarm)))
        else $error("indicator level does not follow polarity");
    AST_LINE_SEL: assert property ((CLK_EN_IN && ind_en && ind_two && !DRDY_ON_LINE_TWO_IN)
        |=> GP_LINE_TWO_OE_OUT && !GP_LINE_ONE_OE_OUT)
        else $error("indicator not routed to line two");
    AST_DRDY_PRIO: assert property ((CLK_EN_IN && DRDY_ON_LINE_ONE_IN) |=> !GP_LINE_ONE_OE_OUT)
        else $error("alarm took a line held by data-ready");
    AST_CFG_WRITE: assert property ((CLK_EN_IN && wr_cfg && upper)
        |=> config_reg[15:8] == $past(REG_WDATA_IN))
        else $error("config upper byte write lost");
    AST_CNT_MASK: assert property (count[0][15:8] == 8'h00 && count[1][15:8] == 8'h00)
        else $error("sample count upper byte not zero");
    AST_RD_DIAG: assert property ((CLK_EN_IN && diag_rd)
        |=> REG_RVALID_OUT && REG_RDATA_OUT[9:8] == $past(flag))
        else $error("status read returned wrong alarm bits");

    COV_BOTH_ALARMS: cover property (flag == 2'b11);
    COV_LINE_TWO_ACTIVE: cover property (GP_LINE_TWO_OE_OUT && GP_LINE_TWO_OUT);
    COV_READ_CLEAR: cover property (flag[0] && diag_rd && CLK_EN_IN ##1 !flag[0]);
endmodule

// >>> include/dsam_pkg.sv
// constants for the dual sensor alarm monitor
// Notes on behaviour
// - Two alarm channels run independently, each with its own threshold, count, source and mode.
// - A static alarm trips when the source is above the threshold if bit 15 is set, below if clear.
// - Threshold bits 13:0 hold the magnitude in the source's own format; bit 14 is unused.
// - A dynamic alarm compares the change over the sample window with the threshold, same polarity.
// - Sample count sits in bits 7:0, bits 15:8 unused, and both 0 and 1 mean a single sample.
// - Config bits 15:12 pick alarm 2's source and 11:8 alarm 1's; 0 disables, 1..7 pick a source.
// - Config bit 7 makes alarm 2 dynamic and bit 6 makes alarm 1 dynamic; clear means static.
// - Config bit 4 makes both alarms use filtered source data instead of raw data.
// - Config bit 2 enables the indicator; when clear the alarms drive no line.
// - Config bit 1 makes the indicator active high when set and active low when clear.
// - Config bit 0 routes the indicator to line two when set and line one when clear.
// - Diagnostic status bit 8 shows alarm 1 and bit 9 shows alarm 2.
// - The dynamic window spans the programmed number of internal sample periods.
// - Status flags clear on each status read and set again at the next sample if still true.
// - Data-ready ownership of a shared line beats the alarm, which beats general-purpose use.
package dsam_pkg;
    localparam int DATA_W = 16;
    localparam int NUM_SRC = 7;
    localparam int HIST_DEPTH = 256;

    localparam logic [6:0] ADDR_THRESH1 = 7'h26;
    localparam logic [6:0] ADDR_THRESH2 = 7'h28;
    localparam logic [6:0] ADDR_COUNT1 = 7'h2a;
    localparam logic [6:0] ADDR_COUNT2 = 7'h2c;
    localparam logic [6:0] ADDR_CONFIG = 7'h2e;
    localparam logic [6:0] ADDR_DIAG = 7'h3c;

    localparam logic [15:0] RST_THRESH = 16'h0000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_CONFIG = 16'h0000;

    localparam logic [15:0] MASK_THRESH = 16'hbfff;
    localparam logic [15:0] MASK_COUNT = 16'h00ff;
    localparam logic [15:0] MASK_CONFIG = 16'hffd7;

    localparam int THR_POL_BIT = 15;
    localparam int THR_MAG_MSB = 13;
    localparam int CNT_MSB = 7;
    localparam int CFG_SRC2_LSB = 12;
    localparam int CFG_SRC1_LSB = 8;
    localparam int CFG_DYN1_BIT = 6;
    localparam int CFG_FILT_BIT = 4;
    localparam int CFG_IND_EN_BIT = 2;
    localparam int CFG_IND_POL_BIT = 1;
    localparam int CFG_IND_LINE_BIT = 0;
    localparam int DIAG_ALARM1_BIT = 8;

    localparam logic [3:0] SRC_DISABLE = 4'h0;
    localparam logic [3:0] SRC_LAST = 4'h7;
endpackage

// >>> src/dsam_channel.sv
// one alarm channel: sample history and threshold compare
`timescale 1ns/10ps
module dsam_channel #(
    parameter int DATA_W = dsam_pkg::DATA_W,
    parameter int DEPTH = dsam_pkg::HIST_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic sample_in,
    input wire logic enable_in,
    input wire logic dynamic_in,
    input wire logic [15:0] threshold_in,
    input wire logic [7:0] count_in,
    input wire logic [DATA_W-1:0] src_in,
    output logic cond_out
);
    localparam int PW = $clog2(DEPTH);

    logic [DATA_W-1:0] hist [DEPTH];
    logic [PW-1:0] wr_ptr;
    wire logic [7:0] span = (count_in <= 8'h01) ? 8'h01 : count_in;
    wire logic [PW-1:0] rd_ptr = PW'(wr_ptr - PW'(span));
    wire logic [DATA_W-1:0] old = hist[rd_ptr];
    wire logic signed [DATA_W:0] cur_ext = {src_in[DATA_W-1], src_in};
    wire logic signed [DATA_W:0] old_ext = {old[DATA_W-1], old};
    wire logic signed [DATA_W:0] delta = cur_ext - old_ext;
    // magnitude sign-extended from bit 13, bit 14 ignored
    wire logic signed [DATA_W:0] thr = {{(DATA_W-13){threshold_in[dsam_pkg::THR_MAG_MSB]}},
        threshold_in[dsam_pkg::THR_MAG_MSB:0]};
    wire logic signed [DATA_W:0] meas = dynamic_in ? delta : cur_ext;
    wire logic pol_gt = threshold_in[dsam_pkg::THR_POL_BIT];
    wire logic trip = pol_gt ? (meas > thr) : (meas < thr);
    wire logic next_cond = enable_in & trip;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            cond_out <= 1'b0;
        end else if (ce_in && sample_in) begin
            wr_ptr <= PW'(wr_ptr + 1'b1);
            cond_out <= next_cond;
        end
    end

    always_ff @(posedge clk_in) begin
        if (ce_in && sample_in) begin
            hist[wr_ptr] <= src_in;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_CH_DISABLED: assert property ((ce_in && sample_in && !enable_in) |=> !cond_out)
        else $error("disabled alarm reported a condition");
    AST_CH_HOLD: assert property (!(ce_in && sample_in) |=> $stable(cond_out))
        else $error("alarm condition changed between samples");
    AST_CH_STATIC: assert property ((ce_in && sample_in && enable_in && !dynamic_in && pol_gt
        && (cur_ext > thr)) |=> cond_out)
        else $error("static greater-than alarm missed");
    COV_CH_DYN: cover property (ce_in && sample_in && enable_in && dynamic_in ##1 cond_out);
endmodule

// >>> testbench/dsam_host_model.sv
// host model driving the byte-wide register port
`timescale 1ns/10ps
module dsam_host_model (
    input wire logic clk_in,
    output logic wr_out,
    output logic rd_out,
    output logic [6:0] addr_out,
    output logic [7:0] wdata_out,
    input wire logic [15:0] rdata_in,
    input wire logic rvalid_in
);
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 7'h55;
        wdata_out = 8'haa;
    end
    // idle address and data lines show the inverse of their last value; write and read strobes go low
    task automatic release_bus();
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
    endtask
    // upper byte then lower byte, back to back
    task automatic wr16(input logic [6:0] a, input logic [15:0] v);
        @(negedge clk_in);
        wr_out = 1'b1;
        addr_out = a | 7'h01;
        wdata_out = v[15:8];
        @(negedge clk_in);
        addr_out = a & 7'h7e;
        wdata_out = v[7:0];
        @(negedge clk_in);
        release_bus();
    endtask
    task automatic rd16(input logic [6:0] a, output logic [15:0] d, output logic ok);
        @(negedge clk_in);
        rd_out = 1'b1;
        addr_out = a;
        // answer stands for one cycle after the taking edge
        @(negedge clk_in);
        ok = rvalid_in;
        d = rdata_in;
        release_bus();
    endtask
endmodule

// >>> testbench/dsam_top_test.sv
// self-checking bench for the dual alarm monitor
`timescale 1ns/10ps
module dsam_top_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strobe = 1'b0;
    logic [111:0] raw = '0;
    logic [111:0] filt = '0;
    logic drdy1 = 1'b0;
    logic drdy2 = 1'b0;
    logic ce = 1'b1;
    logic wr, rd, rvalid, gp1, oe1, gp2, oe2;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [15:0] rdata;
    logic [1:0] flags;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    always #20 clk = ~clk;
    dsam_host_model host (.clk_in(clk), .wr_out(wr), .rd_out(rd), .addr_out(addr),
        .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));
    dsam_top uut (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(ce),
        .SAMPLE_STROBE_IN(strobe), .RAW_DATA_IN(raw), .FILT_DATA_IN(filt),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .DRDY_ON_LINE_ONE_IN(drdy1),
        .DRDY_ON_LINE_TWO_IN(drdy2), .GP_LINE_ONE_OUT(gp1), .GP_LINE_ONE_OE_OUT(oe1),
        .GP_LINE_TWO_OUT(gp2), .GP_LINE_TWO_OE_OUT(oe2), .ALARM_FLAG_OUT(flags));
    task test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdc(input string what, input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        host.rd16(a, d, ok);
        chk("read valid", 16'h0001, 16'(ok));
        chk(what, exp, d);
    endtask
    function automatic logic [111:0] slot(input int code, input logic [15:0] v);
        logic [111:0] b;
        b = '0;
        b[16*(code-1) +: 16] = v;
        return b;
    endfunction
    // one sample period; flags and lines settle two edges later
    task automatic tick();
        @(negedge clk);
        strobe = 1'b1;
        @(negedge clk);
        strobe = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic t_regs();
        logic [6:0] a [5] = '{7'h26, 7'h28, 7'h2a, 7'h2c, 7'h2e};
        logic [15:0] m [5] = '{16'hbfff, 16'hbfff, 16'h00ff, 16'h00ff, 16'hffd7};
        for (int i = 0; i < 5; i++) begin
            rdc("reset value", a[i], 16'h0000);
            host.wr16(a[i], 16'hffff);
            rdc("used bits", a[i], m[i]);
        end
        host.wr16(7'h30, 16'h1234);
        rdc("unmapped", 7'h30, 16'h0000);
        host.wr16(dsam_pkg::ADDR_DIAG, 16'hffff);
        rdc("status", dsam_pkg::ADDR_DIAG, 16'h0000);
        $display("test regs done");
    endtask
    task automatic t_static();
        host.wr16(7'h26, 16'h8064);
        host.wr16(7'h2e, 16'h0106);
        raw = slot(1, 16'd200);
        tick();
        chk("lines", 16'h000c, 16'({oe1, gp1, oe2, gp2}));
        chk("flags", 16'h0001, 16'(flags));
        rdc("status", dsam_pkg::ADDR_DIAG, 16'h0100);
        raw = slot(1, 16'd100);
        tick();
        chk("at threshold", 16'h0000, 16'(gp1));
        chk("flags cleared", 16'h0000, 16'(flags));
        raw = slot(1, 16'd200);
        tick();
        chk("flags again", 16'h0001, 16'(flags));
        drdy1 = 1'b1;
        tick();
        chk("line one owner", 16'h0000, 16'(oe1));
        drdy1 = 1'b0;
        host.wr16(7'h2e, 16'h0102);
        tick();
        chk("lines off", 16'h0000, 16'({oe1, gp1, oe2, gp2}));
        rdc("status held", dsam_pkg::ADDR_DIAG, 16'h0100);
        $display("test static done");
    endtask
    task automatic t_filt();
        host.wr16(7'h28, 16'h02bc);
        host.wr16(7'h2e, 16'h7015);
        raw = slot(7, 16'd1000);
        filt = slot(7, 16'd100);
        tick();
        chk("lines", 16'h0002, 16'({oe1, gp1, oe2, gp2}));
        chk("flags", 16'h0002, 16'(flags));
        rdc("status", dsam_pkg::ADDR_DIAG, 16'h0200);
        host.wr16(7'h2e, 16'h7005);
        tick();
        chk("raw data", 16'h0000, 16'(flags));
        drdy2 = 1'b1;
        tick();
        chk("line two owner", 16'h0000, 16'({oe2, gp2}));
        drdy2 = 1'b0;
        $display("test filter done");
    endtask
    task automatic t_codes();
        host.wr16(7'h26, 16'h8064);
        filt = '0;
        for (int c = 0; c <= 8; c++) begin
            host.wr16(7'h2e, {4'h0, 4'(c), 8'h06});
            raw = (c >= 1 && c < 8) ? slot(c, 16'd200) : {7{16'h00c8}};
            tick();
            chk("source code", (c >= 1 && c < 8) ? 16'h0001 : 16'h0000, 16'(gp1));
        end
        $display("test codes done");
    endtask
    task automatic t_dyn();
        logic [15:0] seq [8] = '{16'd0, 16'd0, 16'd0, 16'd0, 16'd600, 16'd600,
            16'd1200, 16'd1200};
        logic [7:0] hit = 8'b0100_0000;
        host.wr16(7'h28, 16'h83e8);
        host.wr16(7'h2c, 16'h0003);
        host.wr16(7'h2e, 16'h3087);
        for (int i = 0; i < 8; i++) begin
            raw = slot(3, seq[i]);
            tick();
            if (i > 3) chk("window", 16'(hit[i]), 16'(gp2));
        end
        for (int n = 0; n < 2; n++) begin
            host.wr16(7'h2c, 16'(n));
            for (int i = 0; i < 3; i++) begin
                raw = slot(3, (i == 0) ? 16'd0 : 16'd1100);
                tick();
                if (i > 0) chk("one sample", (i == 1) ? 16'h0001 : 16'h0000, 16'(gp2));
            end
        end
        $display("test dynamic done");
    endtask
    // enable low: write, strobe and lines all frozen
    task automatic t_freeze();
        ce = 1'b0;
        host.wr16(7'h2e, 16'h0000);
        raw = slot(3, 16'd3000);
        tick();
        chk("frozen lines", 16'h0002, 16'({oe1, gp1, oe2, gp2}));
        ce = 1'b1;
        rdc("frozen config", 7'h2e, 16'h3087);
        tick();
        chk("thawed lines", 16'h0003, 16'({oe1, gp1, oe2, gp2}));
        $display("test freeze done");
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_regs();
        t_static();
        t_filt();
        t_codes();
        t_dyn();
        t_freeze();
        test_done();
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
endmodule
